// ===== rtl/plmii_map.vh
// constants for the powerline host nibble/di-bit port
`ifndef PLMII_MAP_VH
`define PLMII_MAP_VH

// ==========================================================
// timing
// ==========================================================
`define PLMII_CLK_NS 40
`define PLMII_IFG_NS 960
`define PLMII_IFG_CYC ((`PLMII_IFG_NS + `PLMII_CLK_NS - 1) / `PLMII_CLK_NS)

// ==========================================================
// transmit buffer geometry
// ==========================================================
`define PLMII_TXB_AW 12
`define PLMII_TXB_DEPTH 4096

// ==========================================================
// reduced-mode fill patterns
// ==========================================================
`define PLMII_DIBIT_IDLE 2'h0
`define PLMII_DIBIT_ERR 2'h2

// ==========================================================
// reset values
// ==========================================================
`define PLMII_RST_NIBBLE 4'h0

`endif

// ===== rtl/plmii_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module plmii_sync #(
    parameter WIDTH = 1
) (
    input wire i_clock,              // core clock
    input wire i_reset,              // sync reset, active high
    input wire [WIDTH-1:0] i_async,  // pins from outside the domain
    output wire [WIDTH-1:0] o_sync   // synchronised copy
);

    reg [WIDTH-1:0] meta_reg;  // first stage, read only by second
    reg [WIDTH-1:0] sync_reg;  // second stage

    // ==========================================================
    // two stages
    // ==========================================================
    always @(posedge i_clock) begin
        if (i_reset) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule // plmii_sync

`default_nettype wire

// ===== rtl/plmii_port.v
// host nibble/di-bit port of the powerline transceiver
// Contract
// R1: receive-valid never high with transmit-enable high
// R2: busy rises after enable, falls when ready
// R3: host waits one gap after busy falls
// R4: host applies no jabber timeout to busy
// R5: modulate immediately, buffer one whole packet
// R6: busy, gap, defer to transmit, then valid
// R7: drop busy after receive unless work pending
// R8: receive has priority over transmit
// R9: host raises enable only while busy low
// R10: capture transmit data each reference rising edge
// R11: host drops enable after final data
// R12: valid only after gap, no transmit active
// R13: drive receive data, drop valid after last
// R14: reduced mode moves two bits per clock
// R15: host drives idle 00 when enable low
// R16: host enable spans whole reduced-mode frame
// R17: reduced mode holds 00 before decoding starts
// R18: reduced mode sends 10 after decode error
// R19: reduced valid is carrier plus data valid
// R20: nibble mode moves four bits per clock
// R21: nibble mode flags decode errors on error pin
// R22: mode sampled at reset, static afterwards
`timescale 1ns/1ps
`default_nettype none
`include "plmii_map.vh"

module plmii_port (
    input wire i_clock,                     // core clock, 25 MHz
    input wire i_reset,                     // sync reset, active high
    input wire i_reduced_mode,              // 1 = di-bit mode, sampled in reset
    input wire i_interface_ref_clock,       // reference clock pin from host
    input wire i_host_tx_enable,            // transmit framing pin from host
    input wire [3:0] i_tx_nibble_lines,     // transmit data pins ([1:0] in di-bit mode)
    output reg o_channel_busy,              // carrier/busy to host
    output reg o_rx_valid,                  // receive data valid to host
    output reg o_rx_decode_error,           // receive error to host (nibble mode)
    output reg [3:0] o_rx_nibble_lines,     // receive data ([1:0] in di-bit mode)
    output wire o_mod_valid,                // nibble available to modulator
    output wire [3:0] o_mod_data,           // nibble to modulator
    input wire i_mod_ready,                 // modulator takes the nibble
    input wire i_dem_pending,               // demodulated packet about to be ready
    input wire [3:0] i_dem_data,            // current demodulated nibble
    input wire i_dem_last,                  // current nibble is the frame's last
    input wire i_dem_error,                 // decode error on current nibble
    output reg o_dem_take                   // pulse: current nibble consumed
);

    // ==========================================================
    // states
    // ==========================================================
    localparam ST_IDLE = 3'd0;   // busy low
    localparam ST_TXIN = 3'd1;   // host is filling the buffer
    localparam ST_TXHOLD = 3'd2; // busy held until buffer drains
    localparam ST_RXGAP = 3'd3;  // busy seized, timing a gap
    localparam ST_RXSEND = 3'd4; // receive frame on the pins
    localparam integer IFG_INT = `PLMII_IFG_CYC; // gap length in core cycles
    localparam [4:0] IFG_CYC = IFG_INT[4:0];     // counter-width copy of the gap

    // ==========================================================
    // pin synchronisers and reference-clock edge
    // ==========================================================
    wire [5:0] pins_sync;  // {ref clock, enable, data}
    plmii_sync #(.WIDTH(6)) u_sync (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_async({i_interface_ref_clock, i_host_tx_enable, i_tx_nibble_lines}),
        .o_sync(pins_sync)
    );
    wire ref_s = pins_sync[5];       // synced reference clock
    wire txen_s = pins_sync[4];      // synced transmit enable
    wire [3:0] txd_s = pins_sync[3:0]; // synced transmit data
    reg ref_last_reg;                // previous reference level
    wire tick = ref_s & ~ref_last_reg; // one-cycle enable per rising edge

    // ==========================================================
    // registers
    // ==========================================================
    reg mode_meta_reg;               // first stage for the mode strap pin
    reg mode_reg;                    // latched mode
    reg [2:0] state_reg;             // control state
    reg [4:0] gap_reg;               // gap counter
    reg defer_reg;                   // receive waits behind a transmit
    reg [3:0] txbuf [0:`PLMII_TXB_DEPTH-1]; // one-packet transmit buffer
    reg [`PLMII_TXB_AW:0] wr_reg;    // write pointer
    reg [`PLMII_TXB_AW:0] rd_reg;    // read pointer
    reg half_reg;                    // low di-bit held, waiting for high
    reg [1:0] low_reg;               // held low di-bit
    reg [1:0] phase_reg;             // next di-bit to send: 1 low, 2 high (di-bit mode)
    reg err_reg;                     // sticky decode error in this frame
    reg end_reg;                     // last data already on the pins

    wire [`PLMII_TXB_AW:0] fill = wr_reg - rd_reg; // nibbles buffered
    wire txb_empty = (fill == {(`PLMII_TXB_AW+1){1'b0}});
    wire txb_full = fill[`PLMII_TXB_AW];
    wire rx_err_now = err_reg | i_dem_error;

    // modulator drains as soon as a nibble lands
    // R5: immediate modulation
    assign o_mod_valid = ~txb_empty;
    assign o_mod_data = txbuf[rd_reg[`PLMII_TXB_AW-1:0]];

    // ==========================================================
    // mode capture while reset is held
    // ==========================================================
    // R22: static mode
    always @(posedge i_clock) begin
        mode_meta_reg <= i_reduced_mode;
        if (i_reset) begin
            mode_reg <= mode_meta_reg;
        end
    end

    // ==========================================================
    // transmit buffer write and read
    // ==========================================================
    always @(posedge i_clock) begin
        if (i_reset) begin
            wr_reg <= {(`PLMII_TXB_AW+1){1'b0}};
            rd_reg <= {(`PLMII_TXB_AW+1){1'b0}};
            half_reg <= 1'b0;
            low_reg <= 2'h0;
            ref_last_reg <= 1'b0;
        end else begin
            ref_last_reg <= ref_s;
            // modulator pop
            if (o_mod_valid && i_mod_ready) begin
                rd_reg <= rd_reg + 1'b1;
            end
            // R10: capture on reference edge
            if (tick && txen_s && state_reg == ST_TXIN && !txb_full) begin
                if (!mode_reg) begin
                    // R20: whole nibble per edge
                    txbuf[wr_reg[`PLMII_TXB_AW-1:0]] <= txd_s;
                    wr_reg <= wr_reg + 1'b1;
                end else if (!half_reg) begin
                    // R14: first di-bit held
                    low_reg <= txd_s[1:0];
                    half_reg <= 1'b1;
                end else begin
                    txbuf[wr_reg[`PLMII_TXB_AW-1:0]] <= {txd_s[1:0], low_reg};
                    wr_reg <= wr_reg + 1'b1;
                    half_reg <= 1'b0;
                end
            end else if (state_reg != ST_TXIN) begin
                // odd di-bit at frame end is dropped
                half_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // control state machine
    // ==========================================================
    always @(posedge i_clock) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
            gap_reg <= 5'd0;
            defer_reg <= 1'b0;
            o_channel_busy <= 1'b0;
            o_rx_valid <= 1'b0;
            o_rx_decode_error <= 1'b0;
            o_rx_nibble_lines <= `PLMII_RST_NIBBLE;
            o_dem_take <= 1'b0;
            phase_reg <= 2'd0;
            err_reg <= 1'b0;
            end_reg <= 1'b0;
        end else begin
            o_dem_take <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    o_channel_busy <= 1'b0;
                    if (txen_s) begin
                        // R2: busy after enable
                        o_channel_busy <= 1'b1;
                        state_reg <= ST_TXIN;
                    end else if (i_dem_pending) begin
                        // R6: seize channel first
                        o_channel_busy <= 1'b1;
                        gap_reg <= 5'd0;
                        state_reg <= ST_RXGAP;
                    end
                end
                ST_TXIN: begin
                    // busy holds while host frames data
                    if (!txen_s) begin
                        gap_reg <= 5'd0;
                        // R6: deferred receive takes another gap
                        state_reg <= defer_reg ? ST_RXGAP : ST_TXHOLD;
                        defer_reg <= 1'b0;
                    end
                end
                ST_TXHOLD: begin
                    if (i_dem_pending) begin
                        // R8: receive first
                        gap_reg <= 5'd0;
                        state_reg <= ST_RXGAP;
                    end else if (txb_empty) begin
                        // R2: ready for another packet
                        o_channel_busy <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_RXGAP: begin
                    if (txen_s) begin
                        // R6: defer to host transmit
                        defer_reg <= 1'b1;
                        state_reg <= ST_TXIN;
                    end else if (gap_reg >= IFG_CYC - 5'd1) begin
                        // R12: gap met, no transmit
                        // R1: enable seen low
                        if (tick) begin
                            o_rx_valid <= 1'b1;
                            o_rx_nibble_lines <= `PLMII_RST_NIBBLE;
                            phase_reg <= 2'd0;
                            err_reg <= 1'b0;
                            end_reg <= 1'b0;
                            o_rx_decode_error <= 1'b0;
                            state_reg <= ST_RXSEND;
                            if (!mode_reg) begin
                                // first nibble goes out with valid
                                o_rx_nibble_lines <= i_dem_data;
                                o_rx_decode_error <= i_dem_error;
                                o_dem_take <= 1'b1;
                                end_reg <= i_dem_last;
                            end else begin
                                // R17: lead di-bit 00
                                o_rx_nibble_lines <= {2'h0, `PLMII_DIBIT_IDLE};
                                phase_reg <= 2'd1;
                            end
                        end
                    end else begin
                        gap_reg <= gap_reg + 5'd1;
                    end
                end
                ST_RXSEND: begin
                    if (tick) begin
                        if (end_reg) begin
                            // R13: drop valid after last
                            o_rx_valid <= 1'b0;
                            o_rx_decode_error <= 1'b0;
                            o_rx_nibble_lines <= `PLMII_RST_NIBBLE;
                            gap_reg <= 5'd0;
                            // R7: keep busy if work waits
                            if (i_dem_pending) begin
                                state_reg <= ST_RXGAP;
                            end else if (!txb_empty) begin
                                state_reg <= ST_TXHOLD;
                            end else begin
                                o_channel_busy <= 1'b0;
                                state_reg <= ST_IDLE;
                            end
                        end else if (!mode_reg) begin
                            // R13: nibble per edge
                            o_rx_nibble_lines <= i_dem_data;
                            // R21: error pin
                            o_rx_decode_error <= i_dem_error;
                            o_dem_take <= 1'b1;
                            end_reg <= i_dem_last;
                        end else begin
                            // R19: valid doubles as carrier
                            err_reg <= rx_err_now;
                            if (rx_err_now) begin
                                // R18: error pattern to frame end
                                o_rx_nibble_lines <= {2'h0, `PLMII_DIBIT_ERR};
                            end else if (phase_reg == 2'd1) begin
                                o_rx_nibble_lines <= {2'h0, i_dem_data[1:0]};
                            end else begin
                                o_rx_nibble_lines <= {2'h0, i_dem_data[3:2]};
                            end
                            if (phase_reg == 2'd1) begin
                                phase_reg <= 2'd2;
                            end else begin
                                // high di-bit sent: nibble consumed
                                phase_reg <= 2'd1;
                                o_dem_take <= 1'b1;
                                end_reg <= i_dem_last;
                            end
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // plmii_port

`default_nettype wire

// ===== test/plmii_props.sv
// assertion checker bound to the host nibble/di-bit port
`timescale 1ns/1ps
`default_nettype none
module plmii_props (
    input wire logic i_clock,                  // core clock
    input wire logic i_reset,                  // sync reset, active high
    input wire logic i_reduced_mode,           // di-bit mode
    input wire logic i_host_tx_enable,         // host enable pin
    input wire logic o_channel_busy,           // busy to host
    input wire logic o_rx_valid,               // receive valid
    input wire logic o_rx_decode_error,        // receive error
    input wire logic [3:0] o_rx_nibble_lines,  // receive data
    input wire logic o_mod_valid,              // modulator data waiting
    input wire logic o_dem_take                // nibble consumed pulse
);
    // ==================================================
    // properties
    // ==================================================
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (i_reset);
    rx_tx_apart_a: assert property (o_rx_valid |-> !i_host_tx_enable)
        else $error("rx valid while tx enable high");
    busy_rises_a: assert property ($rose(i_host_tx_enable) && !o_channel_busy |-> ##[1:5] o_channel_busy)
        else $error("busy late after tx enable");
    busy_holds_a: assert property (o_channel_busy && i_host_tx_enable |=> o_channel_busy)
        else $error("busy dropped during frame");
    valid_busy_a: assert property (o_rx_valid |-> o_channel_busy)
        else $error("rx valid without busy");
    rx_gap_a: assert property ($rose(o_rx_valid) |-> $past(o_channel_busy, 23))
        else $error("rx valid before gap");
    rx_end_a: assert property ($fell(o_rx_valid) |-> o_rx_nibble_lines == 4'h0)
        else $error("rx lines not cleared");
    take_pulse_a: assert property (o_dem_take |-> o_rx_valid ##1 !o_dem_take)
        else $error("bad take pulse");
    lead_zero_a: assert property ($rose(o_rx_valid) && i_reduced_mode |-> o_rx_nibble_lines == 4'h0)
        else $error("di-bit lead not zero");
    dibit_lines_a: assert property (i_reduced_mode |-> o_rx_nibble_lines[3:2] == 2'h0 && !o_rx_decode_error)
        else $error("unused lines active in di-bit mode");
    mod_busy_a: assert property ($rose(o_mod_valid) |-> o_channel_busy)
        else $error("modulator data outside frame");
    // main scenarios seen
    rx_seen_c: cover property ($rose(o_rx_valid));
    tx_seen_c: cover property ($rose(o_mod_valid));
    err_seen_c: cover property (o_rx_decode_error);
endmodule // plmii_props
bind plmii_port plmii_props i_plmii_props (.*);
`default_nettype wire

// ===== test/plmii_host.sv
// host-side model: reference clock, transmit framing, receive capture
`timescale 1ns/1ps
`default_nettype none
`include "plmii_map.vh"
module plmii_host (
    input wire logic i_clock,                  // core clock, times the gap
    input wire logic i_reduced_mode,           // di-bit mode
    input wire logic i_channel_busy,           // busy from device
    input wire logic i_rx_valid,               // receive valid
    input wire logic i_rx_decode_error,        // receive error
    input wire logic [3:0] i_rx_nibble_lines,  // receive data
    output logic o_ref_clock,                  // free-running reference clock
    output logic o_tx_enable,                  // transmit enable
    output logic [3:0] o_tx_lines              // transmit data
);
    logic [4:0] rx_q[$];  // captured {error, data}
    // ==================================================
    // reference clock, 320 ns, offset phase
    // ==================================================
    // continuous clock
    initial begin
        o_ref_clock = 1'b0;
        o_tx_enable = 1'b0;
        o_tx_lines = 4'h0;
        #7;
        forever #160 o_ref_clock = ~o_ref_clock;
    end
    // capture receive units on each rising edge
    always @(posedge o_ref_clock) begin
        if (i_rx_valid) rx_q.push_back({i_rx_decode_error, i_rx_nibble_lines});
    end
    // send one frame; low di-bit goes first
    task automatic send(input logic [3:0] d[$]);
        int k;
        forever begin
            wait (i_channel_busy === 1'b0);
            repeat (`PLMII_IFG_CYC) @(posedge i_clock);
            @(negedge o_ref_clock);
            if (i_channel_busy === 1'b0) break;
        end
        for (k = 0; k < d.size(); k++) begin
            o_tx_enable = 1'b1;
            o_tx_lines = i_reduced_mode ? {2'h0, d[k][1:0]} : d[k];
            if (i_reduced_mode) begin
                @(negedge o_ref_clock);
                o_tx_lines = {2'h0, d[k][3:2]};
            end
            @(negedge o_ref_clock);
        end
        o_tx_enable = 1'b0;
        o_tx_lines = 4'h0;
    endtask
endmodule // plmii_host
`default_nettype wire

// ===== test/plmii_port_test.sv
// self-checking bench for the host nibble/di-bit port
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("wrong value %s expected %0h seen %0h", what, exp, got); \
    end \
end
module plmii_port_test;
    logic clock = 1'b0;  // core clock
    logic reset = 1'b1;  // sync reset
    logic reduced = 1'b0;  // mode pin
    logic mod_ready = 1'b0;  // modulator pop
    logic dem_pending = 1'b0;  // receive packet waiting
    logic [3:0] dem_data = 4'h0;  // receive nibble
    logic dem_last = 1'b0;  // last nibble flag
    logic dem_error = 1'b0;  // decode error flag
    wire logic ref_clock, tx_en, busy, rx_valid, rx_err, mod_valid, dem_take;
    wire logic [3:0] tx_lines, rx_lines, mod_data;
    int bad_count = 0;  // mismatches
    int cmp_count = 0;  // comparisons
    always #20 clock = ~clock;
    plmii_port i_plmii_port (.i_clock(clock), .i_reset(reset), .i_reduced_mode(reduced),
        .i_interface_ref_clock(ref_clock), .i_host_tx_enable(tx_en),
        .i_tx_nibble_lines(tx_lines), .o_channel_busy(busy), .o_rx_valid(rx_valid),
        .o_rx_decode_error(rx_err), .o_rx_nibble_lines(rx_lines), .o_mod_valid(mod_valid),
        .o_mod_data(mod_data), .i_mod_ready(mod_ready), .i_dem_pending(dem_pending),
        .i_dem_data(dem_data), .i_dem_last(dem_last), .i_dem_error(dem_error),
        .o_dem_take(dem_take));
    plmii_host i_plmii_host (.i_clock(clock), .i_reduced_mode(reduced),
        .i_channel_busy(busy), .i_rx_valid(rx_valid), .i_rx_decode_error(rx_err),
        .i_rx_nibble_lines(rx_lines), .o_ref_clock(ref_clock), .o_tx_enable(tx_en),
        .o_tx_lines(tx_lines));
    // ==================================================
    // scenarios
    // ==================================================
    // report counts, give the verdict, end the run
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // reset for 5 cycles with the mode pin set, then flush synchronisers
    task automatic do_reset(input logic m);
        @(negedge clock);
        reset = 1'b1;
        reduced = m;
        repeat (5) @(negedge clock);
        reset = 1'b0;
        repeat (4) @(negedge clock);
    endtask
    // frame buffered while the modulator stalls, then drained in order
    task automatic tx_frame();
        logic [3:0] d[$];
        int n;
        d = '{4'h5, 4'hD, 4'h1, 4'hE, 4'h7, 4'hB};
        mod_ready = 1'b0;
        i_plmii_host.send(d);
        repeat (6) @(negedge clock);
        `CHECK("buffered", 1'b1, mod_valid)
        `CHECK("busy held", 1'b1, busy)
        mod_ready = 1'b1;
        n = 0;
        while (mod_valid === 1'b1 && n < 20) begin
            `CHECK("mod nibble", d[n], mod_data)
            n++;
            @(negedge clock);
        end
        `CHECK("mod count", d.size(), n)
        repeat (4) @(negedge clock);
        `CHECK("busy released", 1'b0, busy)
    endtask
    // demodulator side: present nibbles, advance on each take pulse
    task automatic feed(input logic [3:0] d[$], input int err_at);
        int k;
        k = 0;
        dem_pending = 1'b1;
        while (k < d.size()) begin
            dem_data = d[k];
            dem_last = (k == d.size() - 1);
            dem_error = (k == err_at);
            @(negedge clock);
            if (dem_take === 1'b1) k++;
        end
        dem_pending = 1'b0;
        dem_error = 1'b0;
    endtask
    // one received frame, with a decode error at err_at if in range
    task automatic rx_frame(input int err_at);
        logic [3:0] d[$];
        logic [4:0] e[$];
        int k;
        d = '{4'h5, 4'hD, 4'h9, 4'h6, 4'hC};
        i_plmii_host.rx_q.delete();
        feed(d, err_at);
        repeat (30) @(negedge clock);
        if (reduced) e.push_back(5'h00);
        for (k = 0; k < d.size(); k++) begin
            if (!reduced) e.push_back({k == err_at, d[k]});
            else if (k >= err_at) e.push_back(5'h02);
            else e.push_back({3'h0, d[k][1:0]});
            if (reduced) e.push_back(k >= err_at ? 5'h02 : {3'h0, d[k][3:2]});
        end
        `CHECK("rx count", e.size(), i_plmii_host.rx_q.size())
        for (k = 0; k < e.size() && k < i_plmii_host.rx_q.size(); k++) begin
            `CHECK("rx unit", e[k], i_plmii_host.rx_q[k])
        end
        `CHECK("busy after rx", 1'b0, busy)
    endtask
    // receive arrives as the host starts sending: transmit first, then receive
    task automatic rx_defer();
        logic [3:0] t[$];
        t = '{4'h3, 4'hC, 4'hA};
        mod_ready = 1'b1;
        i_plmii_host.rx_q.delete();
        fork
            i_plmii_host.send(t);
            begin
                wait (tx_en === 1'b1);
                @(negedge clock);
                feed(t, 99);
            end
        join
        repeat (30) @(negedge clock);
        `CHECK("deferred rx", reduced ? 7 : 3, i_plmii_host.rx_q.size())
        `CHECK("busy after defer", 1'b0, busy)
    endtask
    // two frames back to back: busy held through the second gap
    task automatic rx_pair();
        logic [3:0] d[$];
        d = '{4'hA, 4'h3};
        i_plmii_host.rx_q.delete();
        feed(d, 99);
        @(negedge clock);
        dem_pending = 1'b1;
        repeat (12) @(negedge clock);
        `CHECK("gap between rx", 2'b01, {rx_valid, busy})
        feed(d, 99);
        repeat (30) @(negedge clock);
        `CHECK("pair count", reduced ? 10 : 4, i_plmii_host.rx_q.size())
        `CHECK("busy after pair", 1'b0, busy)
    endtask
    // main sequence: every scenario in both modes
    initial begin
        for (int m = 0; m < 2; m++) begin
            do_reset(m[0]);
            tx_frame();
            rx_frame(99);
            rx_frame(2);
            rx_defer();
            rx_pair();
        end
        finish_test();
    end
    // watchdog: about eight times the expected run length
    initial begin
        #400000;
        bad_count++;
        finish_test();
    end
endmodule // plmii_port_test
`default_nettype wire
